//--- inc/rdmu_pkg.sv
// Shared constants and carriers of the relative and dB math unit.
// Assumes readings are signed integers in micro-units of the function.
package rdmu_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_FUNC = 5'h04;
    localparam logic [4:0] OFS_NULL = 5'h08;
    localparam logic [4:0] OFS_DBREL = 5'h0C;
    localparam logic [4:0] OFS_DBMREF = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;
    localparam logic [4:0] OFS_RESULT = 5'h18;
    localparam logic [4:0] OFS_DBM = 5'h1C;
    // CTRL fields
    localparam int CTRL_CALC_BIT = 0;
    localparam int CTRL_SEL_LSB = 1;
    localparam logic [1:0] SEL_NULL = 2'h1;
    localparam logic [1:0] SEL_DB = 2'h2;
    // Measurement function codes
    localparam logic [2:0] FN_DCV = 3'h0;
    localparam logic [2:0] FN_ACV = 3'h1;
    localparam logic [2:0] FN_DCI = 3'h2;
    localparam logic [2:0] FN_ACI = 3'h3;
    localparam logic [2:0] FN_OHM2 = 3'h4;
    localparam logic [2:0] FN_OHM4 = 3'h5;
    localparam logic [2:0] FN_FREQ = 3'h6;
    localparam logic [2:0] FN_RATIO = 3'h7;
    // Highest range per function, micro-units
    localparam logic [31:0] TOP_VOLT = 32'h11E1A300;
    localparam logic [31:0] TOP_AMP = 32'h002DC6C0;
    localparam logic [31:0] TOP_OHM = 32'h3B9ACA00;
    localparam logic [31:0] TOP_FREQ = 32'h11E1A300;
    // Null limit is 120 percent of the top range
    localparam logic [31:0] NULL_PCT = 32'h00000078;
    // dB figures in hundredths of a dB
    localparam logic [31:0] DBREL_LIMIT = 32'h00004E20;
    localparam logic [31:0] DBM_FLOOR = 32'hFFFFB1E0;
    localparam logic [31:0] DBM_UV_OFS = 32'h00002328;
    localparam logic [31:0] LOG2_TO_CDB = 32'h0000025A;
    localparam logic [4:0] DBMREF_RESET = 5'h0B;
    localparam logic [4:0] DBMREF_LAST = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic [2:0] func;
        logic signed [31:0] value;
    } rdmu_reading_type;

    typedef struct packed {
        logic valid;
        logic adjusted;
        logic signed [31:0] value;
    } rdmu_result_type;

    typedef enum logic [2:0] {
        ST_PASS = 3'b001,
        ST_NULL = 3'b010,
        ST_DB = 3'b100
    } rdmu_mode_type;
endpackage : rdmu_pkg

//--- src/rdmu_limit_check.sv
// Magnitude limit check for values written by software.
// Assumes the limit is a positive magnitude.
module rdmu_limit_check (
    // Value and limit
    input wire logic signed [31:0] value,
    input wire logic [31:0] limit,
    // Verdict
    output logic inRange
);
    logic [31:0] magnitude;

    // Most negative value cannot be negated; it is always out of range
    assign magnitude = value[31] ? 32'(-value) : 32'(value);
    assign inRange = (magnitude <= limit) && (value != 32'sh80000000);
endmodule : rdmu_limit_check

//--- src/rdmu_dbm_conv.sv
// Converts a voltage reading in microvolts to dBm in hundredths of a dB.
// Assumes the reference resistance index was checked by the caller.
module rdmu_dbm_conv (
    // Reading and reference resistance index
    input wire logic signed [31:0] microVolts,
    input wire logic [4:0] refIndex,
    // dBm, hundredths
    output logic signed [31:0] dbmValue
);
    logic [31:0] magnitude;
    logic [31:0] aligned;
    logic [4:0] topBit;
    logic [12:0] log2Q8;
    logic [31:0] scaled;
    logic [31:0] refLoss;

    assign magnitude = microVolts[31] ? 32'(-microVolts) : 32'(microVolts);

    always_comb begin
        topBit = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (magnitude[i]) begin
                topBit = 5'(i);
            end
        end
    end

    // Linear mantissa: log2(1+f) taken as f, worst error near 0.5 dB; exact at powers of two
    assign aligned = magnitude << (5'h1F - topBit);
    assign log2Q8 = {topBit, aligned[30:23]};
    assign scaled = (32'(log2Q8) * rdmu_pkg::LOG2_TO_CDB) >> 8;

    // Ten times log10 of the reference resistance, hundredths
    always_comb begin
        case (refIndex)
            5'h00: refLoss = 32'h06A3;
            5'h01: refLoss = 32'h0753;
            5'h02: refLoss = 32'h07B0;
            5'h03: refLoss = 32'h07F9;
            5'h04: refLoss = 32'h082D;
            5'h05: refLoss = 32'h0831;
            5'h06: refLoss = 32'h0852;
            5'h07: refLoss = 32'h0880;
            5'h08: refLoss = 32'h095E;
            5'h09: refLoss = 32'h09AD;
            5'h0A: refLoss = 32'h0A8B;
            5'h0B: refLoss = 32'h0ADA;
            5'h0C: refLoss = 32'h0B57;
            5'h0D: refLoss = 32'h0B8A;
            5'h0E: refLoss = 32'h0BB8;
            5'h0F: refLoss = 32'h0C07;
            default: refLoss = 32'h0F3F;
        endcase
    end

    assign dbmValue = (magnitude == 32'h0) ? rdmu_pkg::DBM_FLOOR :
        32'(scaled - rdmu_pkg::DBM_UV_OFS - refLoss);
endmodule : rdmu_dbm_conv

//--- src/rdmu_math_unit.sv
// Relative (null) and dB math stage behind an AXI4-Lite register file.
// Assumes one reading per valid pulse, synchronous to clock.
// Notes on behaviour
// - In null mode the result is reading minus stored null offset.
// - Ratio readings are never null-adjusted.
// - Null offset accepted only within 120 percent of the top range.
// - Null offset clears on reset and on every function change.
// - An accepted null write replaces the earlier offset.
// - Null offset is stored only while the calculate state is on.
// - A configure command clears the null offset.
// - Without a written offset, first reading becomes offset and yields zero.
// - A written offset survives the first reading, which is adjusted by it.
// - dB result is reading in dBm minus stored relative dBm.
// - dB mode applies to dc and ac voltage only.
// - dB relative value accepted only within plus or minus 200.00 dBm.
// - dB relative value clears on reset and on every function change.
// - dB write replaces earlier value, only with calculate state on.
// - dBm refers to one milliwatt into a stored resistance, default 600.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module rdmu_math_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [4:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [4:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Reading in, result out
    input wire rdmu_pkg::rdmu_reading_type reading,
    output rdmu_pkg::rdmu_result_type result
);
    // Bus holding registers
    logic awHeld_q;
    logic [4:0] awAddr_q;
    logic wHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Math state
    logic calcOn_q;
    logic [1:0] mathSel_q;
    logic [2:0] measFunc_q;
    logic signed [31:0] nullOffset_q;
    logic nullWritten_q;
    logic nullLatched_q;
    logic signed [31:0] dbRel_q;
    logic dbWritten_q;
    logic [4:0] dbmRef_q;
    logic rejected_q;
    rdmu_pkg::rdmu_result_type result_q;
    logic signed [31:0] lastDbm_q;

    // Decoded write
    logic doWrite;
    logic [31:0] oldWord;
    logic [31:0] newWord;
    logic writeMapped;
    logic wrCtrl;
    logic wrFunc;
    logic wrNull;
    logic wrDbRel;
    logic wrDbmRef;
    logic nullOk;
    logic dbOk;
    logic refOk;
    logic acceptNull;
    logic acceptDb;
    logic acceptRef;
    logic enableRise;

    // Datapath
    rdmu_pkg::rdmu_mode_type mode;
    logic [31:0] topRange;
    logic [31:0] nullLimit;
    logic signed [31:0] dbmNow;
    logic latchFirst;
    logic signed [31:0] adjusted;

    // Write channel: address and data taken in either order
    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 5'h00;
        end else if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q <= rdmu_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q <= writeMapped ? rdmu_pkg::RESP_OKAY : rdmu_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Byte lanes merge into the current word
    always_comb begin
        case (awAddr_q)
            rdmu_pkg::OFS_CTRL: oldWord = {29'h0, mathSel_q, calcOn_q};
            rdmu_pkg::OFS_FUNC: oldWord = {29'h0, measFunc_q};
            rdmu_pkg::OFS_NULL: oldWord = nullOffset_q;
            rdmu_pkg::OFS_DBREL: oldWord = dbRel_q;
            rdmu_pkg::OFS_DBMREF: oldWord = {27'h0, dbmRef_q};
            default: oldWord = 32'h0;
        endcase
        for (int b = 0; b < 4; b++) begin
            newWord[8*b +: 8] = wStrb_q[b] ? wData_q[8*b +: 8] : oldWord[8*b +: 8];
        end
    end

    assign wrCtrl = doWrite && (awAddr_q == rdmu_pkg::OFS_CTRL);
    assign wrFunc = doWrite && (awAddr_q == rdmu_pkg::OFS_FUNC);
    assign wrNull = doWrite && (awAddr_q == rdmu_pkg::OFS_NULL);
    assign wrDbRel = doWrite && (awAddr_q == rdmu_pkg::OFS_DBREL);
    assign wrDbmRef = doWrite && (awAddr_q == rdmu_pkg::OFS_DBMREF);
    assign writeMapped = (awAddr_q <= rdmu_pkg::OFS_DBM) && (awAddr_q[1:0] == 2'h0);

    // Top range of the selected function
    always_comb begin
        case (measFunc_q)
            rdmu_pkg::FN_DCI, rdmu_pkg::FN_ACI: topRange = rdmu_pkg::TOP_AMP;
            rdmu_pkg::FN_OHM2, rdmu_pkg::FN_OHM4: topRange = rdmu_pkg::TOP_OHM;
            rdmu_pkg::FN_FREQ: topRange = rdmu_pkg::TOP_FREQ;
            default: topRange = rdmu_pkg::TOP_VOLT;
        endcase
    end

    // 120 percent, kept in 64 bits since the ohm range would overflow
    assign nullLimit = 32'((64'(topRange) * 64'(rdmu_pkg::NULL_PCT)) / 64'd100);

    rdmu_limit_check nullCheck (
        .value(newWord),
        .limit(nullLimit),
        .inRange(nullOk)
    );

    rdmu_limit_check dbCheck (
        .value(newWord),
        .limit(rdmu_pkg::DBREL_LIMIT),
        .inRange(dbOk)
    );

    assign refOk = newWord[4:0] <= rdmu_pkg::DBMREF_LAST && newWord[31:5] == 27'h0;
    assign acceptNull = wrNull && calcOn_q && nullOk;
    assign acceptDb = wrDbRel && calcOn_q && dbOk;
    assign acceptRef = wrDbmRef && calcOn_q && refOk;
    assign enableRise = wrCtrl && newWord[rdmu_pkg::CTRL_CALC_BIT] && !calcOn_q;

    // Control and function select
    always_ff @(posedge clock) begin
        if (srst) begin
            calcOn_q <= 1'b0;
            mathSel_q <= 2'h0;
        end else if (wrCtrl) begin
            calcOn_q <= newWord[rdmu_pkg::CTRL_CALC_BIT];
            mathSel_q <= newWord[rdmu_pkg::CTRL_SEL_LSB +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            measFunc_q <= rdmu_pkg::FN_DCV;
        end else if (wrFunc) begin
            measFunc_q <= newWord[2:0];
        end
    end

    // Mode of the stage for the function in force
    always_comb begin
        if (!calcOn_q) begin
            mode = rdmu_pkg::ST_PASS;
        end else if (mathSel_q == rdmu_pkg::SEL_NULL && measFunc_q != rdmu_pkg::FN_RATIO) begin
            mode = rdmu_pkg::ST_NULL;
        end else if (mathSel_q == rdmu_pkg::SEL_DB &&
                (measFunc_q == rdmu_pkg::FN_DCV || measFunc_q == rdmu_pkg::FN_ACV)) begin
            mode = rdmu_pkg::ST_DB;
        end else begin
            mode = rdmu_pkg::ST_PASS;
        end
    end

    assign latchFirst = reading.valid && mode == rdmu_pkg::ST_NULL &&
        !nullWritten_q && !nullLatched_q;

    // Null offset; function change is applied last so it wins
    always_ff @(posedge clock) begin
        if (srst) begin
            nullOffset_q <= 32'sh0;
        end else begin
            if (latchFirst) begin
                nullOffset_q <= reading.value;
            end
            if (acceptNull) begin
                nullOffset_q <= newWord;
            end
            if (wrFunc) begin
                nullOffset_q <= 32'sh0;
            end
        end
    end

    // Written offset is kept across later enables
    always_ff @(posedge clock) begin
        if (srst || wrFunc) begin
            nullWritten_q <= 1'b0;
        end else if (acceptNull) begin
            nullWritten_q <= 1'b1;
        end
    end

    // A captured first reading is taken again after each enable
    always_ff @(posedge clock) begin
        if (srst || wrFunc || enableRise) begin
            nullLatched_q <= 1'b0;
        end else if (latchFirst) begin
            nullLatched_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || wrFunc) begin
            dbRel_q <= 32'sh0;
            dbWritten_q <= 1'b0;
        end else if (acceptDb) begin
            dbRel_q <= newWord;
            dbWritten_q <= 1'b1;
        end
    end

    // Kept across function changes; no non-volatile store here
    always_ff @(posedge clock) begin
        if (srst) begin
            dbmRef_q <= rdmu_pkg::DBMREF_RESET;
        end else if (acceptRef) begin
            dbmRef_q <= newWord[4:0];
        end
    end

    // Refused value writes leave the stored value alone
    always_ff @(posedge clock) begin
        if (srst) begin
            rejected_q <= 1'b0;
        end else if (wrNull || wrDbRel || wrDbmRef) begin
            rejected_q <= !(acceptNull || acceptDb || acceptRef);
        end
    end

    rdmu_dbm_conv dbmConv (
        .microVolts(reading.value),
        .refIndex(dbmRef_q),
        .dbmValue(dbmNow)
    );

    always_comb begin
        case (mode)
            rdmu_pkg::ST_NULL: begin
                adjusted = latchFirst ? 32'sh0 : 32'(reading.value - nullOffset_q);
            end
            rdmu_pkg::ST_DB: begin
                adjusted = 32'(dbmNow - dbRel_q);
            end
            default: begin
                adjusted = reading.value;
            end
        endcase
    end

    // One cycle from reading to result
    always_ff @(posedge clock) begin
        if (srst) begin
            result_q <= '0;
        end else begin
            result_q.valid <= reading.valid;
            if (reading.valid) begin
                result_q.adjusted <= mode != rdmu_pkg::ST_PASS;
                result_q.value <= adjusted;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            lastDbm_q <= rdmu_pkg::DBM_FLOOR;
        end else if (reading.valid && mode == rdmu_pkg::ST_DB) begin
            lastDbm_q <= dbmNow;
        end
    end

    assign result = result_q;

    // Read channel: one answer in flight
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= rdmu_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= rdmu_pkg::RESP_OKAY;
            case (araddr)
                rdmu_pkg::OFS_CTRL: rdata_q <= {29'h0, mathSel_q, calcOn_q};
                rdmu_pkg::OFS_FUNC: rdata_q <= {29'h0, measFunc_q};
                rdmu_pkg::OFS_NULL: rdata_q <= nullOffset_q;
                rdmu_pkg::OFS_DBREL: rdata_q <= dbRel_q;
                rdmu_pkg::OFS_DBMREF: rdata_q <= {27'h0, dbmRef_q};
                rdmu_pkg::OFS_STATUS: begin
                    rdata_q <= {28'h0, rejected_q, dbWritten_q, nullLatched_q, nullWritten_q};
                end
                rdmu_pkg::OFS_RESULT: rdata_q <= result_q.value;
                rdmu_pkg::OFS_DBM: rdata_q <= lastDbm_q;
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= rdmu_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule : rdmu_math_unit

//--- sim/rdmu_math_chk.sv
// Port-level checker for the relative and dB math unit.
// Assumes the master offers full-word writes; snoops CTRL, FUNC and NULL writes.
module rdmu_math_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Write traffic
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [4:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    // Datapath
    input wire rdmu_pkg::rdmu_reading_type reading,
    input wire rdmu_pkg::rdmu_result_type result
);
    logic calc_q, arm_q, bPrev_q;
    logic [1:0] sel_q;
    logic [2:0] func_q;
    logic [4:0] addr_q;
    logic [31:0] data_q;
    logic nullMode, dbVolt;
    assign nullMode = calc_q && sel_q == rdmu_pkg::SEL_NULL && func_q != rdmu_pkg::FN_RATIO;
    assign dbVolt = func_q == rdmu_pkg::FN_DCV || func_q == rdmu_pkg::FN_ACV;
    // Mirror lags the register; readings come later
    always_ff @(posedge clock) begin
        if (srst) begin
            calc_q <= 1'b0;
            sel_q <= 2'h0;
            func_q <= 3'h0;
            arm_q <= 1'b0;
            bPrev_q <= 1'b0;
        end else begin
            bPrev_q <= bvalid;
            if (awvalid && awready) addr_q <= awaddr;
            if (wvalid && wready) data_q <= wdata;
            if (reading.valid && nullMode) arm_q <= 1'b0;
            if (bvalid && !bPrev_q) begin
                if (addr_q == rdmu_pkg::OFS_CTRL) begin
                    calc_q <= data_q[0];
                    sel_q <= data_q[2:1];
                    if (data_q[0] && !calc_q) arm_q <= 1'b1;
                end
                if (addr_q == rdmu_pkg::OFS_FUNC) begin
                    func_q <= data_q[2:0];
                    arm_q <= 1'b1;
                end
                if (addr_q == rdmu_pkg::OFS_NULL) arm_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    ans_timing_a: assert property (reading.valid |=> result.valid)
        else $error("result missing one cycle after reading");
    no_spur_a: assert property (!reading.valid |=> !result.valid)
        else $error("result without reading");
    pass_thru_a: assert property (reading.valid && !calc_q |=>
        result.value == $past(reading.value) && !result.adjusted)
        else $error("reading altered with calculate off");
    ratio_skip_a: assert property (reading.valid && calc_q &&
        func_q == rdmu_pkg::FN_RATIO |=> !result.adjusted)
        else $error("ratio reading adjusted");
    db_scope_a: assert property (reading.valid && calc_q &&
        sel_q == rdmu_pkg::SEL_DB && !dbVolt |=> !result.adjusted)
        else $error("dB applied outside voltage");
    db_apply_a: assert property (reading.valid && calc_q &&
        sel_q == rdmu_pkg::SEL_DB && dbVolt |=> result.adjusted)
        else $error("dB not applied to voltage");
    first_latch_a: assert property (reading.valid && nullMode && arm_q |=>
        result.value == 0)
        else $error("first null reading not zero");
    hold_val_a: assert property (!reading.valid |=> $stable(result.value))
        else $error("result value moved without reading");
endmodule : rdmu_math_chk

bind rdmu_math_unit rdmu_math_chk u_chk (.clock, .srst, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .bvalid, .reading, .result);

//--- sim/rdmu_host_model.sv
// Register bus master standing in for the command interpreter.
// Assumes nothing of slave latency; only the bench watchdog ends a wait.
module rdmu_host_model (
    // Clock
    input wire logic clock,
    // Write side
    output logic awvalid,
    input wire logic awready,
    output logic [4:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // Read side
    output logic arvalid,
    input wire logic arready,
    output logic [4:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial begin
        awvalid = 1'b0;
        awaddr = 5'h1F;
        wvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        bready = 1'b0;
        arvalid = 1'b0;
        araddr = 5'h1F;
        rready = 1'b0;
    end
    // Ready sampled mid-cycle, acted on at the next edge
    task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw, awDone, wDone, tb;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(negedge clock);
            ta = awready && !awDone;
            tw = wready && !wDone;
            @(posedge clock);
            if (ta) begin
                awvalid <= 1'b0;
                awDone = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wDone = 1'b1;
            end
        end
        do begin
            @(negedge clock);
            tb = bvalid;
            resp = bresp;
            @(posedge clock);
        end while (!tb);
        bready <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ta, tr;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(negedge clock);
            ta = arready;
            @(posedge clock);
        end while (!ta);
        arvalid <= 1'b0;
        do begin
            @(negedge clock);
            tr = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clock);
        end while (!tr);
        rready <= 1'b0;
    endtask : rd
endmodule : rdmu_host_model

//--- sim/relative_and_db_math_unit_bench.sv
// Self-checking bench for the relative and dB math unit.
// Assumes the host model drives the bus, the bench the readings.
module relative_and_db_math_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    rdmu_pkg::rdmu_reading_type reading = '0;
    rdmu_pkg::rdmu_result_type result, res;
    int num_errors = 0;
    int n_compared = 0;
    always #10 clock = ~clock;
    rdmu_math_unit u_dut (.clock, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .reading, .result);
    rdmu_host_model u_host (.clock, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp);
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task final_report;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task put(input logic [4:0] a, input logic [31:0] d);
        u_host.wr(a, d, rsp);
    endtask : put
    task peek(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] d;
        u_host.rd(a, d, rsp);
        chk(d, e);
    endtask : peek
    // Off-cycle value is inverted so a stale value cannot pass
    task send(input logic [31:0] v);
        @(posedge clock);
        reading <= '{valid: 1'b1, func: rdmu_pkg::FN_DCV, value: v};
        @(posedge clock);
        reading <= '{valid: 1'b0, func: rdmu_pkg::FN_DCV, value: ~v};
        @(negedge clock);
        res = result;
        chk(32'(res.valid), 32'h1);
    endtask : send
    task near(input int e);
        chk(32'(($signed(res.value) - e <= 15) && (e - $signed(res.value) <= 15)), 32'h1);
    endtask : near
    task t_reset;
        peek(rdmu_pkg::OFS_CTRL, 32'h0);
        peek(rdmu_pkg::OFS_NULL, 32'h0);
        peek(rdmu_pkg::OFS_DBMREF, {27'h0, rdmu_pkg::DBMREF_RESET});
        peek(rdmu_pkg::OFS_DBM, rdmu_pkg::DBM_FLOOR);
        peek(5'h02, 32'h0);
        chk(32'(rsp), 32'(rdmu_pkg::RESP_SLVERR));
        put(5'h06, 32'h1);
        chk(32'(rsp), 32'(rdmu_pkg::RESP_SLVERR));
        put(rdmu_pkg::OFS_CTRL, 32'h2);
        send(32'h12345678);
        chk(res.value, 32'h12345678);
        chk(32'(res.adjusted), 32'h0);
    endtask : t_reset
    task t_null;
        put(rdmu_pkg::OFS_NULL, 32'h5);
        peek(rdmu_pkg::OFS_NULL, 32'h0);
        peek(rdmu_pkg::OFS_STATUS, 32'h8);
        put(rdmu_pkg::OFS_CTRL, 32'h3);
        put(rdmu_pkg::OFS_NULL, 32'd200);
        put(rdmu_pkg::OFS_NULL, 32'd100);
        peek(rdmu_pkg::OFS_NULL, 32'd100);
        send(32'd1000);
        chk(res.value, 32'd900);
        send(32'd50);
        chk(res.value, -32'sd50);
        put(rdmu_pkg::OFS_NULL, 32'h15752A01);
        peek(rdmu_pkg::OFS_NULL, 32'd100);
        put(rdmu_pkg::OFS_NULL, 32'h15752A00);
        peek(rdmu_pkg::OFS_NULL, 32'h15752A00);
        put(rdmu_pkg::OFS_NULL, 32'hEA8AD600);
        peek(rdmu_pkg::OFS_NULL, 32'hEA8AD600);
    endtask : t_null
    task t_clear;
        put(rdmu_pkg::OFS_FUNC, {29'h0, rdmu_pkg::FN_DCV});
        peek(rdmu_pkg::OFS_NULL, 32'h0);
        send(32'd500);
        chk(res.value, 32'h0);
        send(32'd700);
        chk(res.value, 32'd200);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        peek(rdmu_pkg::OFS_STATUS, 32'h0);
        send(32'd700);
        chk(res.value, 32'd700);
        put(rdmu_pkg::OFS_FUNC, {29'h0, rdmu_pkg::FN_RATIO});
        put(rdmu_pkg::OFS_CTRL, 32'h3);
        send(32'd1234);
        chk(res.value, 32'd1234);
        chk(32'(res.adjusted), 32'h0);
    endtask : t_clear
    task t_db;
        put(rdmu_pkg::OFS_FUNC, {29'h0, rdmu_pkg::FN_DCV});
        put(rdmu_pkg::OFS_CTRL, 32'h5);
        put(rdmu_pkg::OFS_DBREL, 32'd100);
        put(rdmu_pkg::OFS_DBREL, 32'd20000);
        put(rdmu_pkg::OFS_DBREL, 32'd20001);
        peek(rdmu_pkg::OFS_DBREL, 32'd20000);
        // 2^19 uV into 600 ohm is -3.39 dBm
        send(32'd524288);
        chk(32'(res.adjusted), 32'h1);
        near(-20339);
        put(rdmu_pkg::OFS_FUNC, {29'h0, rdmu_pkg::FN_ACV});
        peek(rdmu_pkg::OFS_DBREL, 32'h0);
        send(32'd524288);
        near(-339);
        put(rdmu_pkg::OFS_FUNC, {29'h0, rdmu_pkg::FN_DCI});
        send(32'd524288);
        chk(res.value, 32'd524288);
        put(rdmu_pkg::OFS_CTRL, 32'h4);
        put(rdmu_pkg::OFS_DBREL, 32'd300);
        peek(rdmu_pkg::OFS_DBREL, 32'h0);
    endtask : t_db
    initial begin
        #1000000;
        num_errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_null();
        t_clear();
        t_db();
        final_report();
    end
endmodule : relative_and_db_math_unit_bench
